// *** design/led_blink_pkg.sv ***
// constants, field layouts and decode tables for the led blink sequencer
// assumes a single 100 MHz core clock; the register port is a plain strobe port
package led_blink_pkg;

  // register offsets
  localparam logic [7:0] OUTPUT_CONTROL_ADDR = 8'h00;
  localparam logic [7:0] RED1_TIMES_ADDR = 8'h01;
  localparam logic [7:0] RED1_CYCLE_ADDR = 8'h02;
  localparam logic [7:0] GREEN1_TIMES_ADDR = 8'h03;
  localparam logic [7:0] GREEN1_CYCLE_ADDR = 8'h04;
  localparam logic [7:0] BLUE1_TIMES_ADDR = 8'h05;
  localparam logic [7:0] BLUE1_CYCLE_ADDR = 8'h06;

  // output control fields
  localparam int GROUP_ONE_MODE_BIT = 7;
  localparam int GROUP_TWO_MODE_BIT = 6;
  localparam int ENABLE_FIELD_MSB = 5;
  localparam int OUTPUT_COUNT = 6;
  localparam int GROUP_SIZE = 3;

  // reset values
  localparam logic [7:0] OUTPUT_CONTROL_RESET = 8'hc0;
  localparam logic [7:0] TIMES_RESET = 8'h00;
  localparam logic [3:0] CYCLE_RESET = 4'h0;

  // cycle register layout: bit 3 blink enable, bits 2..0 period code
  localparam int CYCLE_FIELD_WIDTH = 4;

  // mode selection value that hands group one to the blink sequencer
  localparam logic [1:0] MODE_BLINK_GROUP_ONE = 2'h1;

  // timing
  localparam int unsigned CORE_CLK_HZ = 100_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned CYCLES_PER_MS_DEFAULT = CORE_CLK_HZ / MS_PER_S;
  localparam int unsigned PERMILLE_STEPS = 1000;
  localparam logic [9:0] PHASE_LAST = 10'h3e7;
  localparam int unsigned LONGEST_PERIOD_MS = 5000;
  localparam int STEP_WIDTH = 20;

  typedef struct packed
  {
    logic [3:0] onCode;
    logic [3:0] offCode;
  } blink_times_t;

  typedef struct packed
  {
    logic blinkEnable;
    logic [2:0] periodCode;
  } blink_cycle_t;

  typedef struct packed
  {
    blink_times_t times;
    blink_cycle_t cycle;
  } blink_config_t;

  // on/off code to per-mille of the period
  function automatic logic [9:0] decodeFraction(input logic [3:0] code);
    unique case (code)
      4'h0: decodeFraction = 10'h000; // 0 %
      4'h1: decodeFraction = 10'h00a; // 1 %
      4'h2: decodeFraction = 10'h019; // 2.5 %
      4'h3: decodeFraction = 10'h032; // 5 %
      4'h4: decodeFraction = 10'h04b; // 7.5 %
      4'h5: decodeFraction = 10'h064; // 10 %
      4'h6: decodeFraction = 10'h096; // 15 %
      4'h7: decodeFraction = 10'h0c8; // 20 %
      4'h8: decodeFraction = 10'h12c; // 30 %
      4'h9: decodeFraction = 10'h190; // 40 %
      4'ha: decodeFraction = 10'h1f4; // 50 %
      4'hb: decodeFraction = 10'h258; // 60 %
      4'hc: decodeFraction = 10'h2bc; // 70 %
      4'hd: decodeFraction = 10'h320; // 80 %
      4'he: decodeFraction = 10'h384; // 90 %
      4'hf: decodeFraction = 10'h3e8; // 100 %
    endcase
  endfunction

  // period code to period in milliseconds
  function automatic logic [12:0] decodePeriodMs(input logic [2:0] code);
    unique case (code)
      3'h0: decodePeriodMs = 13'h0064; // 0.1 s
      3'h1: decodePeriodMs = 13'h00fa; // 0.25 s
      3'h2: decodePeriodMs = 13'h01f4; // 0.5 s
      3'h3: decodePeriodMs = 13'h03e8; // 1 s
      3'h4: decodePeriodMs = 13'h07d0; // 2 s
      3'h5: decodePeriodMs = 13'h0bb8; // 3 s
      3'h6: decodePeriodMs = 13'h0fa0; // 4 s
      3'h7: decodePeriodMs = 13'h1388; // 5 s
    endcase
  endfunction

endpackage

// *** design/led_blink_sequencer.sv ***
// register file and blink sequencer for six led driver outputs in two groups
// assumes register strobes and mode/gate inputs are synchronous to core_clk
//
// Notes on behaviour
// - bit 7 selects group one sink or switch
// - bit 6 selects group two sink or switch
// - bits 5..0 enable six outputs individually
// - reset: mode bits one, all else zero
// - times registers: upper nibble on, lower off
// - four-bit codes decode to fixed percentages
// - cycle registers: enable bit 3, code 2..0
// - blink enable picks generator over static enable
// - three-bit code selects blink period
// - blinking applies only when mode equals 01
// - start gate lets sequences run or holds them
`timescale 1ns/1ps

module led_blink_sequencer
#(
  parameter int unsigned CYCLES_PER_MS = led_blink_pkg::CYCLES_PER_MS_DEFAULT
)
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic regWriteEn,
  input wire logic regReadEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWriteData,
  output logic [7:0] regReadData,
  output logic regReadValid,
  input wire logic [1:0] ledModeSelect,
  input wire logic blinkStartGate,
  output logic [led_blink_pkg::OUTPUT_COUNT-1:0] ledOutputOn,
  output logic groupOneSwitchMode,
  output logic groupTwoSwitchMode
);
  import led_blink_pkg::*;

  // refuse a timebase that cannot be counted by the prescaler
  initial
  begin
    if (CYCLES_PER_MS < 1 ||
        (LONGEST_PERIOD_MS * CYCLES_PER_MS) / PERMILLE_STEPS >= (1 << STEP_WIDTH))
    begin
      $error("CYCLES_PER_MS out of range");
    end
    // a period that is not a whole number of steps would come out short of its code
    if (((32'(decodePeriodMs(3'h0)) * CYCLES_PER_MS) % PERMILLE_STEPS) != 0 ||
        ((32'(decodePeriodMs(3'h1)) * CYCLES_PER_MS) % PERMILLE_STEPS) != 0)
    begin
      $error("CYCLES_PER_MS does not give exact blink periods");
    end
  end

  // register state
  logic [7:0] outputControl_reg; // mode bits and static enables
  logic [7:0] outputControl_next;
  blink_config_t blinkConfig_reg [GROUP_SIZE]; // index 0 red, 1 green, 2 blue
  blink_config_t blinkConfig_next [GROUP_SIZE];
  logic [7:0] readData_reg; // held until the next read strobe
  logic [7:0] readData_next;
  logic readValid_reg; // one-cycle pulse per read
  logic readValid_next;

  // sequencer state, one set per group-one colour
  logic [STEP_WIDTH-1:0] prescale_reg [GROUP_SIZE]; // cycles within a per-mille step
  logic [STEP_WIDTH-1:0] prescale_next [GROUP_SIZE];
  logic [9:0] phase_reg [GROUP_SIZE]; // per-mille position within the period
  logic [9:0] phase_next [GROUP_SIZE];
  logic [OUTPUT_COUNT-1:0] ledOn_reg; // driver output states
  logic [OUTPUT_COUNT-1:0] ledOn_next;

  // cycles per per-mille step of a period; never below one
  function automatic logic [STEP_WIDTH-1:0] stepCycles(input logic [2:0] code);
    logic [31:0] wide;
    wide = (32'(decodePeriodMs(code)) * CYCLES_PER_MS) / PERMILLE_STEPS;
    if (wide == 32'h0)
      stepCycles = STEP_WIDTH'(1);
    else
      stepCycles = wide[STEP_WIDTH-1:0];
  endfunction

  // read mux; unmapped offsets read zero
  function automatic logic [7:0] readMux(input logic [7:0] addr);
    unique case (addr)
      OUTPUT_CONTROL_ADDR: readMux = outputControl_reg;
      RED1_TIMES_ADDR: readMux = blinkConfig_reg[0].times;
      GREEN1_TIMES_ADDR: readMux = blinkConfig_reg[1].times;
      BLUE1_TIMES_ADDR: readMux = blinkConfig_reg[2].times;
      RED1_CYCLE_ADDR: readMux = {4'h0, blinkConfig_reg[0].cycle}; // upper nibble zero
      GREEN1_CYCLE_ADDR: readMux = {4'h0, blinkConfig_reg[1].cycle};
      BLUE1_CYCLE_ADDR: readMux = {4'h0, blinkConfig_reg[2].cycle};
      default: readMux = 8'h00;
    endcase
  endfunction

  // register writes and reads
  always_comb
  begin
    outputControl_next = outputControl_reg;
    for (int i = 0; i < GROUP_SIZE; i++)
    begin
      blinkConfig_next[i] = blinkConfig_reg[i];
    end
    readData_next = readData_reg;
    readValid_next = 1'b0;
    if (regWriteEn)
    begin
      // whole-byte writes; read-only cycle bits are dropped
      unique case (regAddr)
        OUTPUT_CONTROL_ADDR: outputControl_next = regWriteData;
        RED1_TIMES_ADDR: blinkConfig_next[0].times = regWriteData;
        GREEN1_TIMES_ADDR: blinkConfig_next[1].times = regWriteData;
        BLUE1_TIMES_ADDR: blinkConfig_next[2].times = regWriteData;
        RED1_CYCLE_ADDR: blinkConfig_next[0].cycle = regWriteData[3:0];
        GREEN1_CYCLE_ADDR: blinkConfig_next[1].cycle = regWriteData[3:0];
        BLUE1_CYCLE_ADDR: blinkConfig_next[2].cycle = regWriteData[3:0];
        default:
        begin
          // unmapped write ignored
        end
      endcase
    end
    if (regReadEn)
    begin
      // read shows state before a same-cycle write
      readData_next = readMux(regAddr);
      readValid_next = 1'b1;
    end
  end

  // register file flops
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      outputControl_reg <= OUTPUT_CONTROL_RESET;
      for (int i = 0; i < GROUP_SIZE; i++)
      begin
        blinkConfig_reg[i] <= {TIMES_RESET, CYCLE_RESET};
      end
      readData_reg <= 8'h00;
      readValid_reg <= 1'b0;
    end
    else
    begin
      outputControl_reg <= outputControl_next;
      for (int i = 0; i < GROUP_SIZE; i++)
      begin
        blinkConfig_reg[i] <= blinkConfig_next[i];
      end
      readData_reg <= readData_next;
      readValid_reg <= readValid_next;
    end
  end

  // blink timebase and output selection
  always_comb
  begin
    logic blinkMode;
    logic running;
    logic blinkLevel;
    blinkMode = (ledModeSelect == MODE_BLINK_GROUP_ONE);
    running = 1'b0;
    blinkLevel = 1'b0;
    // group two follows its static enables; it has no blink sequencer
    ledOn_next = outputControl_reg[OUTPUT_COUNT-1:0];
    for (int i = 0; i < GROUP_SIZE; i++)
    begin
      running = blinkMode && blinkConfig_reg[i].cycle.blinkEnable && blinkStartGate;
      prescale_next[i] = prescale_reg[i];
      phase_next[i] = phase_reg[i];
      if (!running)
      begin
        // held at period start so a released gate begins a fresh period
        prescale_next[i] = '0;
        phase_next[i] = '0;
      end
      else if (prescale_reg[i] >= stepCycles(blinkConfig_reg[i].cycle.periodCode) - 1'b1)
      begin
        // >= keeps a shortened period from overshooting after a code change
        prescale_next[i] = '0;
        phase_next[i] = (phase_reg[i] >= PHASE_LAST) ? 10'h000 : phase_reg[i] + 10'h001;
      end
      else
      begin
        prescale_next[i] = prescale_reg[i] + 1'b1;
      end
      // on from period start for the on share; off share and remainder dark
      blinkLevel = running && (phase_reg[i] < decodeFraction(blinkConfig_reg[i].times.onCode));
      if (blinkMode && blinkConfig_reg[i].cycle.blinkEnable)
      begin
        ledOn_next[ENABLE_FIELD_MSB - i] = blinkLevel;
      end
      else
      begin
        ledOn_next[ENABLE_FIELD_MSB - i] = outputControl_reg[ENABLE_FIELD_MSB - i];
      end
    end
  end

  // sequencer flops
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < GROUP_SIZE; i++)
      begin
        prescale_reg[i] <= '0;
        phase_reg[i] <= '0;
      end
      ledOn_reg <= '0;
    end
    else
    begin
      for (int i = 0; i < GROUP_SIZE; i++)
      begin
        prescale_reg[i] <= prescale_next[i];
        phase_reg[i] <= phase_next[i];
      end
      ledOn_reg <= ledOn_next;
    end
  end

  // outputs straight from flops
  assign regReadData = readData_reg;
  assign regReadValid = readValid_reg;
  assign ledOutputOn = ledOn_reg;
  assign groupOneSwitchMode = outputControl_reg[GROUP_ONE_MODE_BIT];
  assign groupTwoSwitchMode = outputControl_reg[GROUP_TWO_MODE_BIT];

endmodule // led_blink_sequencer

// *** testbench/led_blink_sequencer_properties.sv ***
// port checker for the led blink sequencer
// assumes one core_clk domain and the strobe register port
`timescale 1ns/1ps
module led_blink_sequencer_properties
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic regWriteEn,
  input wire logic regReadEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWriteData,
  input wire logic [7:0] regReadData,
  input wire logic regReadValid,
  input wire logic [1:0] ledModeSelect,
  input wire logic blinkStartGate,
  input wire logic [led_blink_pkg::OUTPUT_COUNT-1:0] ledOutputOn,
  input wire logic groupOneSwitchMode,
  input wire logic groupTwoSwitchMode
);
  logic [7:0] ctrlReg; // shadow of the control register
  logic redBlinkReg; // shadow of the red blink enable
  logic ctrlWr; // control register write this cycle
  assign ctrlWr = regWriteEn && regAddr == 8'h00;
  // shadows follow writes so outputs can be tied to their cause
  always_ff @(posedge core_clk or negedge arst_n)
    if (!arst_n)
    begin
      ctrlReg <= 8'hc0;
      redBlinkReg <= 1'b0;
    end
    else
    begin
      if (ctrlWr) ctrlReg <= regWriteData;
      if (regWriteEn && regAddr == 8'h02) redBlinkReg <= regWriteData[3];
    end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  AST_MODE_ONE: assert property (
    ctrlWr |=> groupOneSwitchMode == $past(regWriteData[7])) else $error("group one mode");
  AST_MODE_TWO: assert property (
    ctrlWr |=> groupTwoSwitchMode == $past(regWriteData[6])) else $error("group two mode");
  AST_MODE_HOLD: assert property (
    !ctrlWr |=> $stable(groupTwoSwitchMode)) else $error("mode changed unasked");
  AST_GROUP_TWO: assert property (
    ledOutputOn[2:0] == $past(ctrlReg[2:0])) else $error("group two enables");
  AST_STATIC_ONE: assert property (
    $past(ledModeSelect) != 2'h1 |-> ledOutputOn[5:3] == $past(ctrlReg[5:3]))
    else $error("group one not static");
  AST_GATE_OFF: assert property (
    $past(ledModeSelect) == 2'h1 && $past(redBlinkReg) && !$past(blinkStartGate)
    |-> !ledOutputOn[5]) else $error("blink ran with gate low");
  AST_CTRL_READ: assert property (
    regReadEn && regAddr == 8'h00 |=> regReadValid && regReadData == $past(ctrlReg))
    else $error("control readback");
  AST_CYCLE_HIGH: assert property (
    regReadEn && regAddr inside {8'h02, 8'h04, 8'h06} |=> regReadData[7:4] == 4'h0)
    else $error("cycle upper bits set");
  AST_UNMAPPED: assert property (
    regReadEn && regAddr > 8'h06 |=> regReadData == 8'h00) else $error("unmapped read");
endmodule // led_blink_sequencer_properties

bind led_blink_sequencer led_blink_sequencer_properties u_props (.core_clk(core_clk),
  .arst_n(arst_n), .regWriteEn(regWriteEn), .regReadEn(regReadEn), .regAddr(regAddr),
  .regWriteData(regWriteData), .regReadData(regReadData), .regReadValid(regReadValid),
  .ledModeSelect(ledModeSelect), .blinkStartGate(blinkStartGate), .ledOutputOn(ledOutputOn),
  .groupOneSwitchMode(groupOneSwitchMode), .groupTwoSwitchMode(groupTwoSwitchMode));

// *** testbench/led_load_model.sv ***
// six led loads that tally their lit cycles
// assumes outputs are sampled on core_clk rising edges
`timescale 1ns/1ps
module led_load_model
(
  input wire logic core_clk,
  input wire logic clearCount, // restart all tallies
  input wire logic [5:0] ledOutputOn,
  output int unsigned litCount [6] // lit cycles per load
);
  // a lit load draws current on every sampled cycle
  always_ff @(posedge core_clk)
    for (int i = 0; i < 6; i++)
      litCount[i] <= clearCount ? 0 : litCount[i] + ledOutputOn[i];
endmodule // led_load_model

// *** testbench/test_led_blink_sequencer.sv ***
// self-checking bench for the led blink sequencer
// assumes 100 MHz core_clk; blink timebase shortened to 20 cycles per ms
`timescale 1ns/1ps
module test_led_blink_sequencer;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic regWriteEn = 1'b0;
  logic regReadEn = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWriteData = 8'h00;
  logic [1:0] ledModeSelect = 2'h0;
  logic blinkStartGate = 1'b0;
  logic clearCount = 1'b1;
  logic [7:0] regReadData;
  logic regReadValid;
  logic [5:0] ledOutputOn;
  logic groupOneSwitchMode;
  logic groupTwoSwitchMode;
  int unsigned litCount [6];
  int n_mismatch = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [7:0] expQ [$]; // pending read results
  logic [7:0] d;
  // on share in per-mille per code, period in ms per code
  int frac [16] = '{0, 10, 25, 50, 75, 100, 150, 200, 300, 400, 500, 600, 700, 800, 900, 1000};
  int ms [8] = '{100, 250, 500, 1000, 2000, 3000, 4000, 5000};
  led_blink_sequencer #(.CYCLES_PER_MS(20)) u_dut (.core_clk(core_clk), .arst_n(arst_n),
    .regWriteEn(regWriteEn), .regReadEn(regReadEn), .regAddr(regAddr),
    .regWriteData(regWriteData), .regReadData(regReadData), .regReadValid(regReadValid),
    .ledModeSelect(ledModeSelect), .blinkStartGate(blinkStartGate), .ledOutputOn(ledOutputOn),
    .groupOneSwitchMode(groupOneSwitchMode), .groupTwoSwitchMode(groupTwoSwitchMode));
  led_load_model u_load (.core_clk(core_clk), .clearCount(clearCount),
    .ledOutputOn(ledOutputOn), .litCount(litCount));
  initial
    forever #5 core_clk = ~core_clk;
  task automatic conclude();
    $display("mismatches=%0d comparisons=%0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmp(input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic cmpCount(input int e, input int g);
    comparisons++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    regWriteEn <= 1'b1;
    regAddr <= a;
    regWriteData <= v;
    @(posedge core_clk);
    regWriteEn <= 1'b0;
  endtask
  // the expectation is queued as the read is launched
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    regReadEn <= 1'b1;
    regAddr <= a;
    expQ.push_back(e);
    @(posedge core_clk);
    regReadEn <= 1'b0;
  endtask
  // lit cycles of one group one colour over w cycles, optionally from gate release
  task automatic measure(input int w, input logic rel, input int ch, input int e);
    @(posedge core_clk);
    clearCount <= 1'b1;
    blinkStartGate <= rel | blinkStartGate;
    @(posedge core_clk);
    clearCount <= 1'b0;
    repeat (w) @(posedge core_clk);
    #1 cmpCount(e, litCount[5 - ch]);
  endtask
  // read results are matched oldest first
  always @(posedge core_clk)
    if (regReadValid === 1'b1)
      cmp(expQ.size() > 0 ? expQ.pop_front() : 8'hxx, regReadData);
  // hang guard, well above the expected run length
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      n_mismatch++;
      conclude();
    end
  end
  initial
  begin
    void'($urandom(32'h88d3));
    repeat (10) @(posedge core_clk);
    arst_n <= 1'b1;
    cmp(8'hc0, {groupOneSwitchMode, groupTwoSwitchMode, ledOutputOn});
    for (int a = 0; a < 8; a++)
      rd(a[7:0], a == 0 ? 8'hc0 : 8'h00);
    rd(8'h9c, 8'h00);
    // random write then readback, unmapped and read-only bits included
    for (int a = 0; a < 8; a++)
    begin
      d = $urandom;
      wr(a[7:0], d);
      rd(a[7:0], a == 7 ? 8'h00 : (a % 2 == 0 && a > 0) ? {4'h0, d[3:0]} : d);
    end
    repeat (4)
    begin
      d = $urandom;
      wr(8'h00, d);
      repeat (3) @(posedge core_clk);
      #1 cmp(d, {groupOneSwitchMode, groupTwoSwitchMode, ledOutputOn});
    end
    // every on code across the three colours, shortest period
    ledModeSelect <= 2'h1;
    wr(8'h00, 8'h00);
    for (int k = 0; k < 16; k++)
    begin
      blinkStartGate <= 1'b0;
      wr(8'(1 + 2 * (k % 3)), {k[3:0], 4'($urandom)});
      wr(8'(2 + 2 * (k % 3)), 8'h08);
      blinkStartGate <= 1'b1;
      repeat (10) @(posedge core_clk);
      measure(2000, 1'b1, k % 3, 2 * frac[k]);
    end
    blinkStartGate <= 1'b0;
    measure(100, 1'b0, 0, 0);
    ledModeSelect <= 2'h0;
    wr(8'h00, 8'h20);
    measure(100, 1'b0, 0, 100);
    ledModeSelect <= 2'h1;
    wr(8'h02, 8'h00);
    measure(100, 1'b0, 0, 100);
    // every period code at a one percent on share
    wr(8'h01, 8'h10);
    for (int c = 0; c < 8; c++)
    begin
      blinkStartGate <= 1'b0;
      wr(8'h02, {5'h01, c[2:0]});
      measure(2 * ms[c] / 5, 1'b1, 0, ms[c] / 5);
    end
    conclude();
  end
endmodule // test_led_blink_sequencer
